// ---- hw/framer_pkg.sv ----
// shared constants and types for the test control link framer
package framer_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int NRATE = 5;
  localparam int CNT_W = 24;
  localparam int BAUD [NRATE] = '{600, 1200, 2400, 4800, 9600};
  // timer figures in microseconds
  localparam int OCTET_TMR_US [NRATE] = '{25000, 12500, 6300, 3100, 1600};
  localparam int FRAME_TMR_US [NRATE] = '{58300, 29200, 14600, 7300, 3600};
  localparam int BIT_CYC [NRATE] = '{CLK_HZ / BAUD[0], CLK_HZ / BAUD[1],
    CLK_HZ / BAUD[2], CLK_HZ / BAUD[3], CLK_HZ / BAUD[4]};
  // whole-microsecond figures give exact cycle counts at this clock
  localparam int OCTET_TMR_CYC [NRATE] = '{OCTET_TMR_US[0] * CLK_MHZ,
    OCTET_TMR_US[1] * CLK_MHZ, OCTET_TMR_US[2] * CLK_MHZ,
    OCTET_TMR_US[3] * CLK_MHZ, OCTET_TMR_US[4] * CLK_MHZ};
  localparam int FRAME_TMR_CYC [NRATE] = '{FRAME_TMR_US[0] * CLK_MHZ,
    FRAME_TMR_US[1] * CLK_MHZ, FRAME_TMR_US[2] * CLK_MHZ,
    FRAME_TMR_US[3] * CLK_MHZ, FRAME_TMR_US[4] * CLK_MHZ};
  localparam logic [2:0] RATE_MAX = 3'h4;
  localparam logic [3:0] STOP_BIT = 4'h9;
  localparam logic [7:0] LAST_IDX = 8'hfe;
  localparam logic [7:0] ACK_CHAR = 8'h06;
  localparam logic [7:0] NAK_CHAR = 8'h15;
  localparam logic [7:0] RESUME_CHAR = 8'h11;
  localparam logic [7:0] STOP_SENDING_CHAR = 8'h13;
  localparam logic [7:0] START_CHAR = 8'h02;
  localparam logic [7:0] END_CHAR = 8'h03;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  localparam int FIFO_HI = 5;
  localparam int FIFO_LO = 1;
  typedef logic [7:0] byte_t;
  typedef enum logic [4:0] {RX_IDLE = 5'h01, RX_LEN = 5'h02,
    RX_DATA = 5'h04, RX_CHK = 5'h08, RX_END = 5'h10} rx_state_t;
  typedef enum logic [5:0] {TX_IDLE = 6'h01, TX_LEN = 6'h02,
    TX_DATA = 6'h04, TX_CHK = 6'h08, TX_END = 6'h10,
    TX_WAIT = 6'h20} tx_state_t;
endpackage

// ---- hw/stream_if.sv ----
// valid/ready byte stream between the framer and its buffer
`timescale 1ns/100ps
interface stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport source(output data, output valid, input ready);
  modport sink(input data, input valid, output ready);
endinterface

// ---- hw/byte_fifo.sv ----
// shift-down fifo whose head and flags sit in flip-flops
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  stream_if.sink push,
  stream_if.source pop,
  output logic [D-1:0] occ
);
  logic [W-1:0] mem_reg [D];
  logic [D-1:0] vld_reg;
  logic [D-1:0] vld_sh;
  logic [D-1:0] push_mask;
  logic do_pop;

  assign do_pop = pop.valid && pop.ready;
  // no push while full even if a pop frees a slot; keeps ready a flop term
  assign push.ready = !vld_reg[D-1];
  assign pop.valid = vld_reg[0];
  assign pop.data = mem_reg[0];
  assign occ = vld_reg;

  always_comb begin
    vld_sh = do_pop ? (vld_reg >> 1) : vld_reg;
    push_mask = (push.valid && push.ready) ? ((vld_sh + 1'h1) & ~vld_sh)
                                           : '0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vld_reg <= '0;
    end else begin
      vld_reg <= vld_sh | push_mask;
    end
  end

  for (genvar i = 0; i < D; i++) begin : g_slot
    always_ff @(posedge clock) begin
      if (push_mask[i]) begin
        mem_reg[i] <= push.data;
      end else if (do_pop) begin
        if (i < D - 1) begin
          mem_reg[i] <= mem_reg[(i + 1) % D];
        end
      end
    end
  end

  a_full_no_push: assert property (@(posedge clock) disable iff (!rst_n)
    vld_reg[D-1] && !do_pop |=> vld_reg == $past(vld_reg))
    else $error("fifo changed occupancy while full");
endmodule

// ---- hw/test_serial_link_framer.sv ----
// serial framer for the test control link, mobile station side
`timescale 1ns/100ps
module test_serial_link_framer #(
  parameter int bit_cyc [framer_pkg::NRATE] = framer_pkg::BIT_CYC,
  parameter int octet_tmr_cyc [framer_pkg::NRATE] = framer_pkg::OCTET_TMR_CYC,
  parameter int frame_tmr_cyc [framer_pkg::NRATE] = framer_pkg::FRAME_TMR_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2:0] rate_sel,
  input wire logic link_rx,
  output logic link_tx,
  input wire logic [7:0] frm_data,
  input wire logic frm_valid,
  input wire logic frm_last,
  output logic frm_ready,
  output logic tx_frame_done,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_frame_ok,
  output logic rx_frame_bad
);
  localparam int W = framer_pkg::CNT_W;

  logic rst_meta_reg, rst_n_reg;
  logic [W-1:0] bit_len_reg, half_len_reg, quiet_lim_reg, gap_len_reg;
  logic [2:0] rate_idx;
  logic rx_busy_reg, rx_stb_reg;
  logic [W-1:0] rx_cnt_reg, quiet_reg, gap_reg;
  logic [3:0] rx_bit_reg;
  framer_pkg::byte_t rx_sh_reg, rx_left_reg, rx_xor_reg;
  logic rx_chk_ok_reg, rx_ok_reg, rx_bad_reg;
  framer_pkg::rx_state_t rx_st_reg;
  logic push_v_reg;
  framer_pkg::byte_t push_d_reg;
  logic [framer_pkg::FIFO_D-1:0] occ;
  logic rep_pend_reg, rep_ack_reg, xoff_sent_reg, remote_stop_reg;
  logic tx_busy_reg, link_tx_reg;
  logic [W-1:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic [8:0] tx_sh_reg;
  framer_pkg::tx_state_t tx_st_reg;
  framer_pkg::byte_t buf_mem [256];
  framer_pkg::byte_t wr_idx_reg, rd_idx_reg, buf_len_reg, tx_xor_reg;
  logic buf_full_reg, frm_ready_reg, done_reg;
  logic in_frame, quiet_long, rx_timeout, start_hit, ctl_stb;
  logic want_stop, want_xon, mid_frame;
  logic go_frm, go_rep, go_flow, tx_go, last_octet;
  framer_pkg::byte_t tx_byte;

  stream_if #(.W(framer_pkg::FIFO_W)) push_if ();
  stream_if #(.W(framer_pkg::FIFO_W)) pop_if ();

  // release of the asynchronous reset is synchronised here
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'h0;
      rst_n_reg <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  assign rate_idx = (rate_sel > framer_pkg::RATE_MAX) ? framer_pkg::RATE_MAX
                                                      : rate_sel;

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bit_len_reg <= '0;
      half_len_reg <= '0;
      quiet_lim_reg <= '0;
      gap_len_reg <= '0;
    end else begin
      bit_len_reg <= W'(bit_cyc[rate_idx]);
      half_len_reg <= W'(bit_cyc[rate_idx] / 2);
      quiet_lim_reg <= W'(2 * octet_tmr_cyc[rate_idx]);
      gap_len_reg <= W'(frame_tmr_cyc[rate_idx]);
    end
  end

  // receiver: centre of start bit, then one bit period per sample
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rx_busy_reg <= 1'h0;
      rx_cnt_reg <= '0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_stb_reg <= 1'h0;
    end else begin
      rx_stb_reg <= 1'h0;
      if (!rx_busy_reg) begin
        if (!link_rx) begin
          rx_busy_reg <= 1'h1;
          rx_cnt_reg <= half_len_reg;
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - 1'h1;
      end else begin
        rx_cnt_reg <= bit_len_reg - 1'h1;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0) begin
          // a start bit gone high by mid-bit was a glitch
          if (link_rx) begin
            rx_busy_reg <= 1'h0;
          end
        end else if (rx_bit_reg == framer_pkg::STOP_BIT) begin
          rx_busy_reg <= 1'h0;
          // a low stop bit is a framing error; the octet is dropped
          rx_stb_reg <= link_rx;
        end else begin
          rx_sh_reg <= {link_rx, rx_sh_reg[7:1]};
        end
      end
    end
  end

  // silence since the last received octet, saturating
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      quiet_reg <= '1;
    end else if (rx_stb_reg) begin
      quiet_reg <= '0;
    end else if (quiet_reg != '1) begin
      quiet_reg <= quiet_reg + 1'h1;
    end
  end

  assign in_frame = rx_st_reg != framer_pkg::RX_IDLE;
  assign quiet_long = quiet_reg > quiet_lim_reg;
  assign rx_timeout = in_frame && quiet_long;
  assign start_hit = rx_stb_reg && !in_frame && quiet_long &&
                     rx_sh_reg == framer_pkg::START_CHAR;
  assign ctl_stb = rx_stb_reg && !in_frame && !start_hit;

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rx_st_reg <= framer_pkg::RX_IDLE;
      rx_left_reg <= 8'h00;
      rx_xor_reg <= 8'h00;
      rx_chk_ok_reg <= 1'h0;
      rx_ok_reg <= 1'h0;
      rx_bad_reg <= 1'h0;
    end else begin
      rx_ok_reg <= 1'h0;
      rx_bad_reg <= 1'h0;
      if (rx_timeout) begin
        rx_st_reg <= framer_pkg::RX_IDLE;
        rx_bad_reg <= 1'h1;
      end else if (rx_stb_reg) begin
        unique case (rx_st_reg)
          framer_pkg::RX_IDLE: begin
            if (start_hit) begin
              rx_st_reg <= framer_pkg::RX_LEN;
              rx_xor_reg <= framer_pkg::START_CHAR;
            end
          end
          framer_pkg::RX_LEN: begin
            rx_left_reg <= rx_sh_reg;
            rx_xor_reg <= rx_xor_reg ^ rx_sh_reg;
            rx_st_reg <= (rx_sh_reg == 8'h00) ? framer_pkg::RX_CHK
                                              : framer_pkg::RX_DATA;
          end
          framer_pkg::RX_DATA: begin
            rx_left_reg <= rx_left_reg - 8'h01;
            rx_xor_reg <= rx_xor_reg ^ rx_sh_reg;
            if (rx_left_reg == 8'h01) begin
              rx_st_reg <= framer_pkg::RX_CHK;
            end
          end
          framer_pkg::RX_CHK: begin
            rx_chk_ok_reg <= rx_sh_reg == rx_xor_reg;
            rx_st_reg <= framer_pkg::RX_END;
          end
          framer_pkg::RX_END: begin
            rx_st_reg <= framer_pkg::RX_IDLE;
            rx_ok_reg <= rx_chk_ok_reg && rx_sh_reg == framer_pkg::END_CHAR;
            rx_bad_reg <= !(rx_chk_ok_reg &&
                            rx_sh_reg == framer_pkg::END_CHAR);
          end
        endcase
      end
    end
  end

  // data octets go out as they arrive; the verdict pulses after the frame
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      push_v_reg <= 1'h0;
      push_d_reg <= 8'h00;
    end else begin
      push_v_reg <= rx_stb_reg && rx_st_reg == framer_pkg::RX_DATA &&
                    !rx_timeout;
      push_d_reg <= rx_sh_reg;
    end
  end

  assign push_if.valid = push_v_reg;
  assign push_if.data = push_d_reg;
  assign pop_if.ready = rx_ready;
  assign rx_data = pop_if.data;
  assign rx_valid = pop_if.valid;
  assign rx_frame_ok = rx_ok_reg;
  assign rx_frame_bad = rx_bad_reg;

  byte_fifo #(.W(framer_pkg::FIFO_W), .D(framer_pkg::FIFO_D)) u_fifo (
    .clock(clock),
    .rst_n(rst_n_reg),
    .push(push_if.sink),
    .pop(pop_if.source),
    .occ(occ)
  );

  // reply latch; a new verdict wins over the clear
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rep_pend_reg <= 1'h0;
      rep_ack_reg <= 1'h0;
    end else if (rx_ok_reg || rx_bad_reg) begin
      rep_pend_reg <= 1'h1;
      rep_ack_reg <= rx_ok_reg;
    end else if (go_rep) begin
      rep_pend_reg <= 1'h0;
    end
  end

  // high water while receiving means no room for a following frame
  assign want_stop = in_frame && occ[framer_pkg::FIFO_HI] && !xoff_sent_reg;
  assign want_xon = xoff_sent_reg && !occ[framer_pkg::FIFO_LO];

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      xoff_sent_reg <= 1'h0;
    end else if (go_flow) begin
      xoff_sent_reg <= want_stop;
    end
  end

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      remote_stop_reg <= 1'h0;
    end else if (ctl_stb && rx_sh_reg == framer_pkg::STOP_SENDING_CHAR) begin
      remote_stop_reg <= 1'h1;
    end else if (ctl_stb && rx_sh_reg == framer_pkg::RESUME_CHAR) begin
      remote_stop_reg <= 1'h0;
    end
  end

  assign mid_frame = !(tx_st_reg == framer_pkg::TX_IDLE ||
                       tx_st_reg == framer_pkg::TX_WAIT);

  // transmit choice: frame body first, then replies, flow, new frame
  always_comb begin
    go_frm = 1'h0;
    go_rep = 1'h0;
    go_flow = 1'h0;
    tx_byte = framer_pkg::END_CHAR;
    if (!tx_busy_reg) begin
      if (mid_frame) begin
        // body octets go back to back, well inside the limit
        go_frm = 1'h1;
        if (tx_st_reg == framer_pkg::TX_LEN) begin
          tx_byte = buf_len_reg;
        end else if (tx_st_reg == framer_pkg::TX_DATA) begin
          tx_byte = buf_mem[rd_idx_reg];
        end else if (tx_st_reg == framer_pkg::TX_CHK) begin
          tx_byte = tx_xor_reg;
        end
      end else if (gap_reg == '0) begin
        if (rep_pend_reg) begin
          go_rep = 1'h1;
          tx_byte = rep_ack_reg ? framer_pkg::ACK_CHAR : framer_pkg::NAK_CHAR;
        end else if (want_stop || want_xon) begin
          go_flow = 1'h1;
          tx_byte = want_stop ? framer_pkg::STOP_SENDING_CHAR
                             : framer_pkg::RESUME_CHAR;
        end else if (tx_st_reg == framer_pkg::TX_IDLE && buf_full_reg &&
                     !remote_stop_reg && !in_frame) begin
          // own frame only while the line is ours
          go_frm = 1'h1;
          tx_byte = framer_pkg::START_CHAR;
        end
      end
    end
  end

  assign tx_go = go_frm || go_rep || go_flow;
  assign last_octet = go_rep || go_flow ||
                      (go_frm && tx_st_reg == framer_pkg::TX_END);

  // gap runs from the start bit of each frame's last octet
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gap_reg <= '0;
    end else if (last_octet) begin
      gap_reg <= gap_len_reg;
    end else if (gap_reg != '0) begin
      gap_reg <= gap_reg - 1'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tx_busy_reg <= 1'h0;
      tx_cnt_reg <= '0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 9'h1ff;
      link_tx_reg <= 1'h1;
    end else if (tx_go) begin
      tx_busy_reg <= 1'h1;
      link_tx_reg <= 1'h0;
      tx_sh_reg <= {1'h1, tx_byte};
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= bit_len_reg - 1'h1;
    end else if (tx_busy_reg) begin
      if (tx_cnt_reg != '0) begin
        tx_cnt_reg <= tx_cnt_reg - 1'h1;
      end else if (tx_bit_reg == framer_pkg::STOP_BIT) begin
        tx_busy_reg <= 1'h0;
      end else begin
        link_tx_reg <= tx_sh_reg[0];
        tx_sh_reg <= {1'h1, tx_sh_reg[8:1]};
        tx_bit_reg <= tx_bit_reg + 4'h1;
        tx_cnt_reg <= bit_len_reg - 1'h1;
      end
    end
  end

  assign link_tx = link_tx_reg;

  always_ff @(posedge clock) begin
    if (frm_valid && frm_ready_reg) begin
      buf_mem[wr_idx_reg] <= frm_data;
    end
  end

  // own frame: load buffer, send, hold until acknowledged
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tx_st_reg <= framer_pkg::TX_IDLE;
      wr_idx_reg <= 8'h00;
      rd_idx_reg <= 8'h00;
      buf_len_reg <= 8'h00;
      tx_xor_reg <= 8'h00;
      buf_full_reg <= 1'h0;
      frm_ready_reg <= 1'h1;
      done_reg <= 1'h0;
    end else begin
      done_reg <= 1'h0;
      if (frm_valid && frm_ready_reg) begin
        wr_idx_reg <= wr_idx_reg + 8'h01;
        // the 255th octet closes the frame
        if (frm_last || wr_idx_reg == framer_pkg::LAST_IDX) begin
          buf_full_reg <= 1'h1;
          frm_ready_reg <= 1'h0;
          buf_len_reg <= wr_idx_reg + 8'h01;
          wr_idx_reg <= 8'h00;
        end
      end
      unique case (tx_st_reg)
        framer_pkg::TX_IDLE: begin
          if (go_frm) begin
            tx_st_reg <= framer_pkg::TX_LEN;
            tx_xor_reg <= framer_pkg::START_CHAR;
            rd_idx_reg <= 8'h00;
          end
        end
        framer_pkg::TX_LEN: begin
          if (go_frm) begin
            tx_xor_reg <= tx_xor_reg ^ buf_len_reg;
            tx_st_reg <= framer_pkg::TX_DATA;
          end
        end
        framer_pkg::TX_DATA: begin
          if (go_frm) begin
            tx_xor_reg <= tx_xor_reg ^ buf_mem[rd_idx_reg];
            rd_idx_reg <= rd_idx_reg + 8'h01;
            if (rd_idx_reg == buf_len_reg - 8'h01) begin
              tx_st_reg <= framer_pkg::TX_CHK;
            end
          end
        end
        framer_pkg::TX_CHK: begin
          if (go_frm) begin
            tx_st_reg <= framer_pkg::TX_END;
          end
        end
        framer_pkg::TX_END: begin
          if (go_frm) begin
            tx_st_reg <= framer_pkg::TX_WAIT;
          end
        end
        framer_pkg::TX_WAIT: begin
          // drop on acknowledge, resend on negative acknowledge
          if (ctl_stb && rx_sh_reg == framer_pkg::ACK_CHAR) begin
            tx_st_reg <= framer_pkg::TX_IDLE;
            buf_full_reg <= 1'h0;
            frm_ready_reg <= 1'h1;
            done_reg <= 1'h1;
          end else if (ctl_stb && rx_sh_reg == framer_pkg::NAK_CHAR) begin
            tx_st_reg <= framer_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  assign frm_ready = frm_ready_reg;
  assign tx_frame_done = done_reg;

  a_start_bit_low: assert property (
    @(posedge clock) disable iff (!rst_n_reg)
    tx_go |=> tx_busy_reg && !link_tx_reg [*2])
    else $error("start bit not driven low");
  a_idle_line_high: assert property (
    @(posedge clock) disable iff (!rst_n_reg)
    !tx_busy_reg && !$past(tx_go) |-> link_tx_reg)
    else $error("idle line not high");
  a_reply_code: assert property (
    @(posedge clock) disable iff (!rst_n_reg)
    go_rep |=> tx_sh_reg[7:0] == ($past(rep_ack_reg) ?
      framer_pkg::ACK_CHAR : framer_pkg::NAK_CHAR))
    else $error("wrong acknowledge code");
  a_check_sent: assert property (
    @(posedge clock) disable iff (!rst_n_reg)
    go_frm && tx_st_reg == framer_pkg::TX_CHK
      |=> tx_sh_reg[7:0] == $past(tx_xor_reg))
    else $error("check octet mismatch");
  a_frame_gap: assert property (
    @(posedge clock) disable iff (!rst_n_reg)
    tx_go && !mid_frame |-> gap_reg == '0)
    else $error("inter frame gap violated");
  a_rx_timeout: assert property (
    @(posedge clock) disable iff (!rst_n_reg)
    rx_timeout |=> rx_st_reg == framer_pkg::RX_IDLE && rx_bad_reg)
    else $error("silent frame not closed");
  a_stop_on_full: assert property (
    @(posedge clock) disable iff (!rst_n_reg)
    go_flow && want_stop |=> xoff_sent_reg &&
      tx_sh_reg[7:0] == framer_pkg::STOP_SENDING_CHAR)
    else $error("stop sending not issued");
  a_octet_spacing: assert property (
    @(posedge clock) disable iff (!rst_n_reg)
    mid_frame && !tx_busy_reg |=> tx_busy_reg)
    else $error("frame body octet delayed");
  a_nak_retry: assert property (
    @(posedge clock) disable iff (!rst_n_reg)
    tx_st_reg == framer_pkg::TX_WAIT && ctl_stb &&
      rx_sh_reg == framer_pkg::NAK_CHAR
      |=> tx_st_reg == framer_pkg::TX_IDLE && buf_full_reg)
    else $error("frame not kept for retransmission");
endmodule

// ---- tb/link_sim.sv ----
// simulator-side model: sends octets on link_rx, decodes link_tx
`timescale 1ns/100ps
module link_sim (
  input wire logic clock,
  input wire logic [15:0] bc,
  output logic line_out,
  input wire logic line_in,
  output logic [7:0] got,
  output logic got_stb
);
  initial begin
    line_out = 1'b1;
    got = 8'h00;
    got_stb = 1'b0;
  end
  // start, lsb first, stop at our rate
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (bc) @(posedge clock);
    end
  endtask
  // mid-bit sampling; a low stop bit yields no strobe
  always begin
    @(negedge line_in);
    repeat (bc / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (bc) @(posedge clock);
      got[i] <= line_in;
    end
    repeat (bc) @(posedge clock);
    got_stb <= line_in;
    @(posedge clock);
    got_stb <= 1'b0;
  end
endmodule

// ---- tb/test_serial_link_framer_tb.sv ----
// self-checking bench for the test control link framer
`timescale 1ns/100ps
module test_serial_link_framer_tb;
  // short per-rate periods keep the run brief; each rate differs
  localparam int BCS [5] = '{40, 36, 32, 28, 24};
  localparam int OTS [5] = '{500, 450, 400, 350, 300};
  localparam int FTS [5] = '{1000, 900, 800, 700, 600};
  logic [15:0] bc = 16'h0020;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] rate_sel = 3'h0;
  logic frm_valid = 1'b0;
  logic frm_last = 1'b0;
  logic rx_ready = 1'b1;
  logic [7:0] frm_data = 8'h00;
  logic link_rx, link_tx, frm_ready, tx_frame_done, rx_valid;
  logic rx_frame_ok, rx_frame_bad, got_stb;
  logic [7:0] rx_data, got;
  logic [31:0] lfsr = 32'h0a7a;
  // expected octets on the wire, delivered data, verdict pulses
  logic [7:0] el[$], ed[$], ev[$], lf[$];
  int num_errors = 0;
  int compares = 0;
  always #2.5 clock = ~clock;
  test_serial_link_framer #(.bit_cyc(BCS), .octet_tmr_cyc(OTS),
    .frame_tmr_cyc(FTS)) test_serial_link_framer_i (.clock(clock),
    .rstn(rstn), .rate_sel(rate_sel), .link_rx(link_rx),
    .link_tx(link_tx), .frm_data(frm_data), .frm_valid(frm_valid),
    .frm_last(frm_last), .frm_ready(frm_ready),
    .tx_frame_done(tx_frame_done), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_frame_ok(rx_frame_ok), .rx_frame_bad(rx_frame_bad));
  link_sim link_sim_i (.clock(clock), .bc(bc), .line_out(link_rx),
    .line_in(link_tx), .got(got), .got_stb(got_stb));
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // new random rate on both sides, only while the line is idle
  task automatic pick_rate();
    logic [2:0] k;
    lfsr = step(lfsr);
    k = (lfsr[2:0] > 3'h4) ? 3'h4 : lfsr[2:0];
    rate_sel <= lfsr[2:0];
    bc <= 16'(BCS[k]);
    repeat (2) @(posedge clock);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    compares++;
    if (a !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task automatic results();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic settle();
    for (int i = 0; i < 20000 && el.size() + ed.size() + ev.size(); i++)
      @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (got_stb === 1'b1)
      chk(got, el.size() ? el.pop_front() : 8'hxx);
    if ((rx_valid & rx_ready) === 1'b1)
      chk(rx_data, ed.size() ? ed.pop_front() : 8'hxx);
    if ((rx_frame_ok | rx_frame_bad | tx_frame_done) === 1'b1)
      chk({5'h0, tx_frame_done, rx_frame_bad, rx_frame_ok},
        ev.size() ? ev.pop_front() : 8'hxx);
  end
  // own frame with its xor check
  task automatic own_frame(input int n);
    logic [7:0] x, c;
    c = 8'h02 ^ n[7:0];
    lf = {8'h02, n[7:0]};
    for (int i = 0; i < n; i++) begin
      lfsr = step(lfsr);
      x = lfsr[7:0];
      c ^= x;
      lf.push_back(x);
      frm_data <= x;
      frm_valid <= 1'b1;
      frm_last <= (i == n - 1);
      @(posedge clock);
      while (frm_ready !== 1'b1) @(posedge clock);
    end
    frm_valid <= 1'b0;
    @(posedge clock);
    chk(8'(frm_ready), 8'h00);
    lf.push_back(c);
    lf.push_back(8'h03);
    el = {el, lf};
  endtask
  // simulator frame after long silence; cut ends by timeout
  task automatic sim_frame(input int n, input logic [7:0] err, input bit cut);
    logic [7:0] x, c;
    repeat (1000) @(posedge clock);
    c = 8'h02 ^ n[7:0];
    link_sim_i.send(8'h02);
    link_sim_i.send(n[7:0]);
    for (int i = 0; i < n; i++) begin
      lfsr = step(lfsr);
      x = lfsr[7:0];
      c ^= x;
      ed.push_back(x);
      link_sim_i.send(x);
    end
    ev.push_back((cut || err) ? 8'h02 : 8'h01);
    el.push_back((cut || err) ? 8'h15 : 8'h06);
    if (!cut) begin
      link_sim_i.send(c ^ err);
      link_sim_i.send(8'h03);
    end
  endtask
  initial begin
    pick_rate();
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    own_frame(3);
    settle();
    // refusal from the simulator forces a resend
    repeat (1000) @(posedge clock);
    el = {el, lf};
    link_sim_i.send(8'h15);
    settle();
    chk(8'(frm_ready), 8'h00);
    repeat (1000) @(posedge clock);
    ev.push_back(8'h04);
    link_sim_i.send(8'h06);
    settle();
    chk(8'(frm_ready), 8'h01);
    // a stop from the simulator holds our next frame back
    link_sim_i.send(8'h13);
    own_frame(1);
    repeat (3000) @(posedge clock);
    chk(8'(el.size()), 8'h05);
    link_sim_i.send(8'h11);
    settle();
    repeat (1000) @(posedge clock);
    ev.push_back(8'h04);
    link_sim_i.send(8'h06);
    settle();
    pick_rate();
    sim_frame(0, 8'h00, 1'b0);
    sim_frame(2, 8'h40, 1'b0);
    sim_frame(3, 8'h00, 1'b1);
    settle();
    // stalled consumer: stop, then resume once drained
    pick_rate();
    rx_ready <= 1'b0;
    el.push_back(8'h13);
    sim_frame(7, 8'h00, 1'b0);
    for (int i = 0; i < 20000 && el.size(); i++) @(posedge clock);
    el.push_back(8'h11);
    rx_ready <= 1'b1;
    settle();
    chk(8'(el.size() + ed.size() + ev.size()), 8'h00);
    results();
  end
  initial begin
    #450_000;
    num_errors++;
    results();
  end
endmodule
